// *** inc/cdr_pkg.sv ***
// package for the clock-recovery override control bank
// assumes one register clock domain shared with the management bus logic
package cdr_pkg;

    // register offsets of this bank
    localparam logic [7:0] REG_START0  = 8'h08;
    localparam logic [7:0] REG_ENABLES = 8'h09;
    localparam logic [7:0] REG_PUMP    = 8'h0A;
    localparam logic [7:0] REG_START1  = 8'h0B;
    localparam int         NUM_REGS    = 4;

    // reset values, listed from index 3 (start1) down to index 0 (start0)
    localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {8'h0F, 8'h10, 8'h00, 8'h00};
    // bits that software may write
    localparam logic [NUM_REGS-1:0][7:0] REG_WMASK = {8'hFF, 8'hFF, 8'hFF, 8'h07};
    // bits that the eeprom loader may write
    localparam logic [NUM_REGS-1:0][7:0] REG_EMASK = {8'hFF, 8'hF0, 8'hFF, 8'h07};

    // enables register bit positions
    localparam int OV_CAP    = 7;
    localparam int OV_LEVEL  = 6;
    localparam int OV_BYPASS = 5;
    localparam int OV_DETPWR = 4;
    localparam int OV_PUMPPD = 3;
    localparam int OV_DIV    = 2;
    localparam int OV_FLD    = 1;
    localparam int LOCK_MODE = 0;

    // pump/reset/lock register bit positions
    localparam int OV_SBT    = 7;
    localparam int OV_ICUR   = 6;
    localparam int OV_TRIP   = 5;
    localparam int OV_F150   = 4;
    localparam int RST_FORCE = 3;
    localparam int RST_VALUE = 2;
    localparam int LCK_FORCE = 1;
    localparam int LCK_VALUE = 0;

    // field positions inside the override source registers
    localparam int CAP_LSB   = 0; // 0x0B[4:0]
    localparam int LVL_LSB   = 0; // 0x1F[4:0]
    localparam int F150_BIT  = 6; // 0x1F[6]
    localparam int LT_LSB    = 5; // 0x1E[7:5]
    localparam int FDEN_BIT  = 0; // 0x1E[0]
    localparam int FLD_BIT   = 1; // 0x1E[1]
    localparam int PDPD_BIT  = 2; // 0x1E[2]
    localparam int VCO_BIT   = 0; // 0x1C[0]
    localparam int IQ_BIT    = 1; // 0x1C[1]
    localparam int FCUR_LSB  = 2; // 0x1C[4:2]
    localparam int PCUR_LSB  = 5; // 0x1C[7:5]
    localparam int FPUMP_BIT = 1; // 0x1B[1]
    localparam int PPUMP_BIT = 0; // 0x1B[0]
    localparam int DIV_LSB   = 4; // 0x18[6:4]
    localparam int SBT_BIT   = 7; // 0x1D[7]

    // controls that reach the analog loop
    typedef struct packed {
        logic [4:0] cap_count;
        logic [4:0] filter_level;
        logic [2:0] loopthru_select;
        logic       freq_detector_enable;
        logic       phase_detector_powerdown;
        logic       oscillator_powerdown;
        logic       quadrature_detector_powerdown;
        logic       freq_pump_powerdown;
        logic       phase_pump_powerdown;
        logic [2:0] divider_select;
        logic       lock_detector_powerdown;
        logic       single_bit_enable;
        logic [2:0] phase_pump_current;
        logic [2:0] freq_pump_current;
        logic [7:0] filter_trip;
        logic       filter_150_mode;
        logic       recovery_reset;
    } cdr_ctrl_t;

    // raw contents of the registers outside this bank that hold override values
    typedef struct packed {
        logic [7:0] reg16;
        logic [7:0] reg18;
        logic [7:0] reg1b;
        logic [7:0] reg1c;
        logic [7:0] reg1d;
        logic [7:0] reg1e;
        logic [7:0] reg1f;
    } cdr_src_regs_t;

endpackage

// *** src/cdr_override_bank.sv ***
// override control bank of one clock-recovery channel
// assumes register access and eeprom load arrive synchronous to core_clk_in
// Behaviour
// [RULE1] capacitor count force selects 0x0B[4:0] over internal count
// [RULE2] filter level force selects 0x1F[4:0] as loop-filter dac value
// [RULE3] loop-through force drives both loop-through selects from 0x1E[7:5]
// [RULE4] detector power force takes fd enable, oscillator_powerdown, iq from 0x1E/0x1C
// [RULE5] pump power force takes both pump power-downs from 0x1B[1:0]
// [RULE6] divider force 1 uses 0x18[6:4]; 0 follows internal divider select
// [RULE7] lock detector force takes its power-down from 0x1E[1]
// [RULE8] lock-mode bit keeps frequency detector enabled in locked state; with the detector power force set, fd enable comes from 0x1E[0] instead
// [RULE9] single-bit-transition force takes its enable from 0x1D[7]
// [RULE10] phase pump current force takes settings from 0x1C[7:5]
// [RULE11] frequency pump current force takes settings from 0x1C[4:2]
// [RULE12] filter trip force takes both trip levels from 0x16[7:0]
// [RULE13] filter 150 force takes mode from 0x1F[6]; force resets to 1
// [RULE14] recovery reset force drives loop reset from 0x0A[2]
// [RULE15] forced reset value 1 holds loop in reset, 0 runs it
// [RULE16] lock force reports lock from 0x0A[0] instead of detector
// [RULE17] writable lock value bit gives the forced lock state
// [RULE18] start setting 0 bits 2:0 writable, eeprom loadable, reset zero
// [RULE19] each force is a plain selector acting without further trigger
`timescale 1ns/100ps
module cdr_override_bank (
    // clock, reset, enable
    input  wire logic                 core_clk_in,
    input  wire logic                 resetn_in,
    input  wire logic                 clk_en_in,
    // register access port
    input  wire logic                 reg_wr_in,
    input  wire logic [7:0]           reg_addr_in,
    input  wire logic [7:0]           reg_wdata_in,
    output logic      [7:0]           reg_rdata_out,
    // eeprom load port, shares address and data
    input  wire logic                 ee_load_in,
    // internally generated controls and state
    input  wire cdr_pkg::cdr_ctrl_t   int_ctrl_in,
    input  wire logic                 int_lock_in,
    input  wire logic                 sm_locked_in,
    // override source registers outside the bank
    input  wire cdr_pkg::cdr_src_regs_t src_regs_in,
    // controls to the analog loop
    output cdr_pkg::cdr_ctrl_t        ctrl_out,
    output logic                      lock_out,
    output logic      [2:0]           start_cap0_out
);

    // register storage, index 0..3 = 0x08..0x0B
    logic [7:0]               regs_q [cdr_pkg::NUM_REGS];
    logic [cdr_pkg::NUM_REGS-1:0] bus_sel;
    logic [cdr_pkg::NUM_REGS-1:0] ee_sel;
    logic [7:0]               en_reg;
    logic [7:0]               pump_reg;
    logic [7:0]               start1_reg;
    cdr_pkg::cdr_ctrl_t       ctrl_d;
    cdr_pkg::cdr_ctrl_t       ctrl_q;
    logic                     lock_d;
    logic                     lock_q;
    logic [7:0]               rdata_q;

    // one-hot register select, shared by bus write and eeprom load
    function automatic logic [cdr_pkg::NUM_REGS-1:0] reg_hit(input logic [7:0] addr);
        reg_hit = 4'h0;
        if (addr == cdr_pkg::REG_START0) begin
            reg_hit = 4'h1;
        end else if (addr == cdr_pkg::REG_ENABLES) begin
            reg_hit = 4'h2;
        end else if (addr == cdr_pkg::REG_PUMP) begin
            reg_hit = 4'h4;
        end else if (addr == cdr_pkg::REG_START1) begin
            reg_hit = 4'h8;
        end
    endfunction

    // a bus write wins over an eeprom load in the same cycle
    assign bus_sel = reg_wr_in ? reg_hit(reg_addr_in) : 4'h0;
    assign ee_sel  = (ee_load_in && !reg_wr_in) ? reg_hit(reg_addr_in) : 4'h0;

    // each register keeps its non-writable bits, so reserved bits read zero
    for (genvar i = 0; i < cdr_pkg::NUM_REGS; i++) begin : g_reg
        always_ff @(posedge core_clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                regs_q[i] <= cdr_pkg::REG_RESET[i]; // RULE13 RULE18
            end else if (clk_en_in) begin
                if (bus_sel[i]) begin
                    regs_q[i] <= (regs_q[i] & ~cdr_pkg::REG_WMASK[i])
                               | (reg_wdata_in & cdr_pkg::REG_WMASK[i]); // RULE17 RULE18
                end else if (ee_sel[i]) begin
                    regs_q[i] <= (regs_q[i] & ~cdr_pkg::REG_EMASK[i])
                               | (reg_wdata_in & cdr_pkg::REG_EMASK[i]); // RULE18
                end
            end
        end
    end

    assign en_reg     = regs_q[1];
    assign pump_reg   = regs_q[2];
    assign start1_reg = regs_q[3];

    // override selectors; no trigger beyond the enable bit itself
    always_comb begin
        ctrl_d = int_ctrl_in; // RULE19
        if (en_reg[cdr_pkg::OV_CAP]) begin
            ctrl_d.cap_count = start1_reg[cdr_pkg::CAP_LSB +: 5]; // RULE1
        end
        if (en_reg[cdr_pkg::OV_LEVEL]) begin
            ctrl_d.filter_level = src_regs_in.reg1f[cdr_pkg::LVL_LSB +: 5]; // RULE2
        end
        if (en_reg[cdr_pkg::OV_BYPASS]) begin
            ctrl_d.loopthru_select = src_regs_in.reg1e[cdr_pkg::LT_LSB +: 3]; // RULE3
        end
        if (en_reg[cdr_pkg::LOCK_MODE] && sm_locked_in) begin
            ctrl_d.freq_detector_enable = 1'b1; // RULE8
        end
        // the power force is applied last so an explicit value beats lock mode
        if (en_reg[cdr_pkg::OV_DETPWR]) begin
            ctrl_d.freq_detector_enable = src_regs_in.reg1e[cdr_pkg::FDEN_BIT]; // RULE4
            ctrl_d.phase_detector_powerdown = src_regs_in.reg1e[cdr_pkg::PDPD_BIT];
            ctrl_d.oscillator_powerdown = src_regs_in.reg1c[cdr_pkg::VCO_BIT];
            ctrl_d.quadrature_detector_powerdown = src_regs_in.reg1c[cdr_pkg::IQ_BIT];
        end
        if (en_reg[cdr_pkg::OV_PUMPPD]) begin
            ctrl_d.freq_pump_powerdown = src_regs_in.reg1b[cdr_pkg::FPUMP_BIT]; // RULE5
            ctrl_d.phase_pump_powerdown = src_regs_in.reg1b[cdr_pkg::PPUMP_BIT];
        end
        if (en_reg[cdr_pkg::OV_DIV]) begin
            ctrl_d.divider_select = src_regs_in.reg18[cdr_pkg::DIV_LSB +: 3]; // RULE6
        end
        if (en_reg[cdr_pkg::OV_FLD]) begin
            ctrl_d.lock_detector_powerdown = src_regs_in.reg1e[cdr_pkg::FLD_BIT]; // RULE7
        end
        if (pump_reg[cdr_pkg::OV_SBT]) begin
            ctrl_d.single_bit_enable = src_regs_in.reg1d[cdr_pkg::SBT_BIT]; // RULE9
        end
        // one enable bit serves both pump current overrides
        if (pump_reg[cdr_pkg::OV_ICUR]) begin
            ctrl_d.phase_pump_current = src_regs_in.reg1c[cdr_pkg::PCUR_LSB +: 3]; // RULE10
            ctrl_d.freq_pump_current = src_regs_in.reg1c[cdr_pkg::FCUR_LSB +: 3]; // RULE11
        end
        if (pump_reg[cdr_pkg::OV_TRIP]) begin
            ctrl_d.filter_trip = src_regs_in.reg16; // RULE12
        end
        if (pump_reg[cdr_pkg::OV_F150]) begin
            ctrl_d.filter_150_mode = src_regs_in.reg1f[cdr_pkg::F150_BIT]; // RULE13
        end
        if (pump_reg[cdr_pkg::RST_FORCE]) begin
            ctrl_d.recovery_reset = pump_reg[cdr_pkg::RST_VALUE]; // RULE14 RULE15
        end
    end

    // lock report selector
    always_comb begin
        lock_d = pump_reg[cdr_pkg::LCK_FORCE] ? pump_reg[cdr_pkg::LCK_VALUE]
                                               : int_lock_in; // RULE16 RULE17
    end

    // registered controls; one cycle of latency keeps analog inputs glitch free
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_q <= '0;
        end else if (clk_en_in) begin
            ctrl_q <= ctrl_d; // RULE19
        end
    end

    // registered lock report
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            lock_q <= 1'b0;
        end else if (clk_en_in) begin
            lock_q <= lock_d;
        end
    end

    // read data, registered one cycle after the address; unmapped reads zero
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_q <= 8'h00;
        end else if (clk_en_in) begin
            if (reg_addr_in == cdr_pkg::REG_START0) begin
                rdata_q <= regs_q[0];
            end else if (reg_addr_in == cdr_pkg::REG_ENABLES) begin
                rdata_q <= regs_q[1];
            end else if (reg_addr_in == cdr_pkg::REG_PUMP) begin
                rdata_q <= regs_q[2];
            end else if (reg_addr_in == cdr_pkg::REG_START1) begin
                rdata_q <= regs_q[3];
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    assign ctrl_out       = ctrl_q;
    assign lock_out       = lock_q;
    assign reg_rdata_out  = rdata_q;
    assign start_cap0_out = regs_q[0][2:0]; // RULE18

    // checks, all in the register clock domain
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!resetn_in);

    chk_cap_force: assert property ( // RULE1
        clk_en_in && en_reg[7] |=> ctrl_out.cap_count == $past(start1_reg[4:0]))
        else $error("capacitor count not taken from override register");

    chk_level_force: assert property ( // RULE2
        clk_en_in && en_reg[6] |=> ctrl_out.filter_level == $past(src_regs_in.reg1f[4:0]))
        else $error("filter level not taken from override register");

    chk_loopthru_force: assert property ( // RULE3
        clk_en_in && en_reg[5] |=> ctrl_out.loopthru_select == $past(src_regs_in.reg1e[7:5]))
        else $error("loop-through select not overridden");

    chk_detpwr_force: assert property ( // RULE4
        clk_en_in && en_reg[4] |=> ctrl_out.freq_detector_enable == $past(src_regs_in.reg1e[0])
        && ctrl_out.oscillator_powerdown == $past(src_regs_in.reg1c[0]))
        else $error("detector power controls not overridden");

    chk_div_normal: assert property ( // RULE6
        clk_en_in && !en_reg[2] |=> ctrl_out.divider_select == $past(int_ctrl_in.divider_select))
        else $error("divider select does not follow internal value");

    chk_lock_mode: assert property ( // RULE8
        clk_en_in && en_reg[0] && sm_locked_in && !en_reg[4] |=> ctrl_out.freq_detector_enable)
        else $error("frequency detector dropped in locked state");

    chk_pump_current: assert property ( // RULE10
        clk_en_in && pump_reg[6] |=> ctrl_out.phase_pump_current == $past(src_regs_in.reg1c[7:5])
        && ctrl_out.freq_pump_current == $past(src_regs_in.reg1c[4:2]))
        else $error("pump current not overridden");

    chk_reset_force: assert property ( // RULE15
        clk_en_in && pump_reg[3] |=> ctrl_out.recovery_reset == $past(pump_reg[2]))
        else $error("forced recovery reset value not applied");

    chk_lock_force: assert property ( // RULE16
        clk_en_in && pump_reg[1] |=> lock_out == $past(pump_reg[0]))
        else $error("forced lock value not reported");

    chk_freeze_hold: assert property ( // RULE19
        !clk_en_in |=> $stable(ctrl_out) && $stable(lock_out))
        else $error("state changed while clock enable low");

    chk_start0_write: assert property ( // RULE18
        clk_en_in && reg_wr_in && reg_addr_in == cdr_pkg::REG_START0
        |=> start_cap0_out == $past(reg_wdata_in[2:0]))
        else $error("start setting bits not written");

    cov_cap_force: cover property (clk_en_in && en_reg[7] ##1 clk_en_in);
    cov_reset_force: cover property (clk_en_in && pump_reg[3] && pump_reg[2]);
    cov_lock_force: cover property (clk_en_in && pump_reg[1] && !int_lock_in ##1 lock_out);
    cov_ee_load: cover property (clk_en_in && ee_load_in && !reg_wr_in && ee_sel != 4'h0);

endmodule // cdr_override_bank

// *** verification/cdr_override_bank_bench.sv ***
// self-checking bench for the clock-recovery override control bank
// assumes the bank alone, driven at falling edges on its register port
`timescale 1ns/100ps
module cdr_override_bank_bench;
    // clock, reset and port signals
    logic                   core_clk;
    logic                   resetn;
    logic                   clk_en;
    logic                   reg_wr;
    logic [7:0]             reg_addr;
    logic [7:0]             reg_wdata;
    logic [7:0]             reg_rdata;
    logic                   ee_load;
    cdr_pkg::cdr_ctrl_t     int_ctrl;
    logic                   int_lock;
    logic                   sm_locked;
    cdr_pkg::cdr_src_regs_t src_regs;
    cdr_pkg::cdr_ctrl_t     ctrl;
    logic                   lock;
    logic [2:0]             start_cap0;
    cdr_pkg::cdr_ctrl_t     exp_c;
    int                     n_fail;
    int                     n_tests;
    // two patterns so every selected field flips between passes
    localparam logic [39:0] IC0 = 40'hA5C369F01E;
    localparam logic [55:0] SR0 = 56'h3C96E15A0FA5C3;
    localparam int          NCODE = 19;
    // control word groups: detector forces, power and divider, pump currents, the rest
    localparam logic [39:0] M1 = 40'hFFFF800000;
    localparam logic [39:0] M2 = 40'h00007F0000;
    localparam logic [39:0] M3 = 40'h000000FC00;
    localparam logic [39:0] M4 = 40'h00000003FF;
    // {enables, pump/reset/lock} register codes, one force at a time then mixes
    localparam logic [15:0] CODES [NCODE] = '{16'h0000, 16'h8000, 16'h4000, 16'h2000,
        16'h1000, 16'h0800, 16'h0400, 16'h0200, 16'h0100, 16'h0080, 16'h0040, 16'h0020,
        16'h0010, 16'h0008, 16'h000C, 16'h0002, 16'h0003, 16'h1100, 16'hFFFF};

    initial core_clk = 1'b0;
    // 125 MHz register clock
    always #4 core_clk = ~core_clk;

    cdr_override_bank u_dut (
        .core_clk_in    (core_clk),
        .resetn_in      (resetn),
        .clk_en_in      (clk_en),
        .reg_wr_in      (reg_wr),
        .reg_addr_in    (reg_addr),
        .reg_wdata_in   (reg_wdata),
        .reg_rdata_out  (reg_rdata),
        .ee_load_in     (ee_load),
        .int_ctrl_in    (int_ctrl),
        .int_lock_in    (int_lock),
        .sm_locked_in   (sm_locked),
        .src_regs_in    (src_regs),
        .ctrl_out       (ctrl),
        .lock_out       (lock),
        .start_cap0_out (start_cap0)
    );

    // reference selection, worked out independently of the design
    function automatic cdr_pkg::cdr_ctrl_t exp_ctrl(input logic [7:0] e9, input logic [7:0] ea,
        input logic [7:0] r0b, input cdr_pkg::cdr_ctrl_t ic, input cdr_pkg::cdr_src_regs_t s,
        input logic lk);
        cdr_pkg::cdr_ctrl_t c;
        c = ic;
        if (e9[7]) c.cap_count = r0b[4:0];
        if (e9[6]) c.filter_level = s.reg1f[4:0];
        if (e9[5]) c.loopthru_select = s.reg1e[7:5];
        if (e9[4]) begin
            c.freq_detector_enable = s.reg1e[0];
            c.phase_detector_powerdown = s.reg1e[2];
            c.oscillator_powerdown = s.reg1c[0];
            c.quadrature_detector_powerdown = s.reg1c[1];
        end
        if (e9[3]) c.freq_pump_powerdown = s.reg1b[1];
        if (e9[3]) c.phase_pump_powerdown = s.reg1b[0];
        if (e9[2]) c.divider_select = s.reg18[6:4];
        if (e9[1]) c.lock_detector_powerdown = s.reg1e[1];
        if (e9[0] && lk && !e9[4]) c.freq_detector_enable = 1'b1;
        if (ea[7]) c.single_bit_enable = s.reg1d[7];
        if (ea[6]) c.phase_pump_current = s.reg1c[7:5];
        if (ea[6]) c.freq_pump_current = s.reg1c[4:2];
        if (ea[5]) c.filter_trip = s.reg16;
        if (ea[4]) c.filter_150_mode = s.reg1f[6];
        if (ea[3]) c.recovery_reset = ea[2];
        return c;
    endfunction

    // one comparison, counted, reported at once on mismatch
    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // m[0] bus write strobe, m[1] eeprom strobe; an idle cycle follows every access
    task automatic acc(input logic [1:0] m, input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = m[0];
        ee_load = m[1];
        @(negedge core_clk);
        reg_wr = 1'b0;
        ee_load = 1'b0;
        @(negedge core_clk);
    endtask

    // read data answers at the same edge that samples the address
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        @(negedge core_clk);
        chk({32'h0, reg_rdata}, {32'h0, exp}, "register read");
    endtask

    task automatic check_resets();
        rd(cdr_pkg::REG_START0, 8'h00);
        rd(cdr_pkg::REG_ENABLES, 8'h00);
        rd(cdr_pkg::REG_PUMP, 8'h10);
        rd(cdr_pkg::REG_START1, 8'h0F);
        rd(8'h0C, 8'h00);
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watchdog, far beyond the 162 cycles the sequence needs
    initial begin
        #200000;
        n_fail++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        wrap_up();
    end

    // main sequence
    initial begin
        n_fail = 0;
        n_tests = 0;
        resetn = 1'b0;
        clk_en = 1'b1;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        ee_load = 1'b0;
        int_ctrl = '0;
        int_lock = 1'b0;
        sm_locked = 1'b0;
        src_regs = SR0;
        repeat (16) @(negedge core_clk);
        chk({ctrl}, 40'h0, "outputs in reset");
        resetn = 1'b1;
        check_resets();
        // filter 150 force is on out of reset, so its source bit shows
        chk(ctrl, exp_ctrl(8'h00, 8'h10, 8'h0F, int_ctrl, src_regs, 1'b0), "reset select");
        // start setting 0: only bits 2:0 stored, eeprom may load them
        acc(2'b01, cdr_pkg::REG_START0, 8'hFF);
        rd(cdr_pkg::REG_START0, 8'h07);
        chk({37'h0, start_cap0}, 40'h7, "start cap bits");
        acc(2'b10, cdr_pkg::REG_START0, 8'h02);
        rd(cdr_pkg::REG_START0, 8'h02);
        acc(2'b01, cdr_pkg::REG_START1, 8'hF5);
        rd(cdr_pkg::REG_START1, 8'hF5);
        // eeprom reaches only the upper nibble of the pump register
        acc(2'b10, cdr_pkg::REG_PUMP, 8'hFF);
        rd(cdr_pkg::REG_PUMP, 8'hF0);
        acc(2'b11, cdr_pkg::REG_PUMP, 8'h0F);
        rd(cdr_pkg::REG_PUMP, 8'h0F);
        acc(2'b01, 8'h0C, 8'hFF);
        rd(8'h0C, 8'h00);
        // a frozen clock enable must drop the write
        clk_en = 1'b0;
        acc(2'b01, cdr_pkg::REG_ENABLES, 8'hFF);
        clk_en = 1'b1;
        rd(cdr_pkg::REG_ENABLES, 8'h00);
        // each force alone and in mixes, inputs swapped under a held setting
        for (int i = 0; i < NCODE; i++) begin
            acc(2'b01, cdr_pkg::REG_ENABLES, CODES[i][15:8]);
            acc(2'b01, cdr_pkg::REG_PUMP, CODES[i][7:0]);
            for (int p = 0; p < 2; p++) begin
                int_ctrl = (p == 1) ? ~IC0 : IC0;
                src_regs = (p == 1) ? ~SR0 : SR0;
                // locked in pass 0 while the internal fd enable is low, so lock mode shows
                sm_locked = ~p[0];
                int_lock = ~p[0];
                @(negedge core_clk);
                exp_c = exp_ctrl(CODES[i][15:8], CODES[i][7:0], 8'hF5, int_ctrl, src_regs,
                    sm_locked);
                chk(ctrl & M1, exp_c & M1, "detector forces");
                chk(ctrl & M2, exp_c & M2, "power, divider");
                chk(ctrl & M3, exp_c & M3, "pump currents");
                chk(ctrl & M4, exp_c & M4, "trip mode reset");
                chk({39'h0, lock}, {39'h0, CODES[i][1] ? CODES[i][0] : int_lock},
                    "reported lock");
            end
        end
        // second reset in mid-run restores every register
        resetn = 1'b0;
        @(negedge core_clk);
        chk(ctrl, 40'h0, "controls in second reset");
        chk({31'h0, lock, reg_rdata}, 40'h0, "lock and read data in second reset");
        resetn = 1'b1;
        check_resets();
        wrap_up();
    end
endmodule // cdr_override_bank_bench
